// ### cmc_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_adc_model (
  input wire logic clk,
  input wire logic en,
  input wire logic [1:0] sel,
  output logic [7:0] data
);
  logic [7:0] junk_q;
  // one clock per conversion, so a late channel switch still reads the old channel
  always @(posedge clk)
  begin
    junk_q <= junk_q + 8'h5B;
    if (en)
    begin
      data <= 8'hA0 | {6'h00, sel};
    end
    else
    begin
      data <= junk_q;
    end
  end
  initial junk_q = 8'h3C;
endmodule : cmc_adc_model
`default_nettype wire

// ### cmc_meas_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cmc_meas_if;
  logic start;
  logic busy;
  logic done;
  logic latch;
  logic [1:0] chan;
  logic [1:0] latch_chan;
  // sequencer side
  modport seq (input start, output busy, output done, output latch, output chan, output latch_chan);
  // controller side
  modport ctrl (output start, input busy, input done, input latch, input chan, input latch_chan);
endinterface : cmc_meas_if
`default_nettype wire

// ### cmc_meas_seq.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_meas_seq #(
  parameter int unsigned MEAS_CYCLES = cmc_pkg::TOTAL_MEASURE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  cmc_meas_if.seq mif
);
  import cmc_pkg::*;

  // each channel gets an equal slice of the total time
  localparam int unsigned PHASE = MEAS_CYCLES / NUM_CH;
  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE - 1);

  typedef struct packed {
    cmc_seq_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] chan;
    logic [1:0] lchan;
    logic latch;
    logic done;
  } cmc_seq_s;

  localparam cmc_seq_s SEQ_RST = '{st: SQ_IDLE, cnt: '0, chan: CH_TEMP, lchan: CH_TEMP, latch: 1'b0, done: 1'b0};

  cmc_seq_s s_q;
  cmc_seq_s s_d;

  // temperature first, then x, y, z; done rides with the z sample
  always_comb
  begin
    s_d = s_q;
    s_d.latch = 1'b0;
    s_d.done = 1'b0;
    case (s_q.st)
      SQ_IDLE:
      begin
        if (mif.start)
        begin
          s_d.st = SQ_RUN;
          s_d.cnt = '0;
          s_d.chan = CH_TEMP;
        end
      end
      SQ_RUN:
      begin
        if (s_q.cnt == PHASE_LAST)
        begin
          s_d.cnt = '0;
          s_d.latch = 1'b1;
          s_d.lchan = s_q.chan;
          if (s_q.chan == CH_Z)
          begin
            s_d.st = SQ_IDLE;
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.chan = 2'(s_q.chan + CH_STEP);
          end
        end
        else
        begin
          s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
        end
      end
      default:
      begin
        s_d = SEQ_RST;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= SEQ_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // all driven straight from state flops
  assign mif.busy = (s_q.st == SQ_RUN);
  assign mif.done = s_q.done;
  assign mif.latch = s_q.latch;
  assign mif.chan = s_q.chan;
  assign mif.latch_chan = s_q.lchan;
endmodule : cmc_meas_seq
`default_nettype wire

// ### cmc_pkg.sv
`default_nettype none
package cmc_pkg;
  // data and address widths of the register port
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;
  // register addresses
  localparam logic [7:0] ADDR_STATUS = 8'hC0;
  localparam logic [7:0] ADDR_TEMP = 8'hC1;
  localparam logic [7:0] ADDR_FZ = 8'hC4;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hE0;
  localparam logic [7:0] ADDR_COND_FIRST = 8'hE1;
  localparam logic [7:0] ADDR_COND_LAST = 8'hE6;
  localparam logic [7:0] ADDR_CUR_READ = 8'hFF;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  // measurement condition storage
  localparam int unsigned COND_NUM = 6;
  localparam logic [7:0] COND_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // mode select field inside the mode control register
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_MSB = 1;
  localparam logic [1:0] MODE_MEASURE = 2'h0;
  localparam logic [1:0] MODE_EEPROM = 2'h2;
  localparam logic [1:0] MODE_PDOWN = 2'h3;
  // status register layout
  localparam int unsigned ST_INT_BIT = 0;
  localparam int unsigned ST_MODE_LSB = 1;
  localparam int unsigned ST_MODE_MSB = 2;
  localparam int unsigned ST_BUSY_BIT = 3;
  // converter channels, in measurement order
  localparam int unsigned NUM_CH = 4;
  localparam logic [1:0] CH_TEMP = 2'h0;
  localparam logic [1:0] CH_Z = 2'h3;
  localparam logic [1:0] CH_STEP = 2'h1;
  // total measure time, typical
  localparam real TOTAL_MEASURE_TIME_MS = 12.56;
  localparam real CLK_FREQ_MHZ = 100.0;
  localparam int unsigned TOTAL_MEASURE_CYCLES = int'(TOTAL_MEASURE_TIME_MS * 1000.0 * CLK_FREQ_MHZ);
  localparam int unsigned CNT_W = 24;

  typedef enum logic [1:0] {MD_PDOWN, MD_MEASURE, MD_EEPROM} cmc_mode_e;
  typedef enum logic {SQ_IDLE, SQ_RUN} cmc_seq_e;

  // mode state as seen in the status register
  function automatic logic [1:0] mode_code(input cmc_mode_e m);
    logic [1:0] c;
    c = MODE_PDOWN;
    if (m == MD_MEASURE)
    begin
      c = MODE_MEASURE;
    end
    else if (m == MD_EEPROM)
    begin
      c = MODE_EEPROM;
    end
    return c;
  endfunction : mode_code
endpackage : cmc_pkg
`default_nettype wire

// ### cmc_result_byte.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_result_byte #(
  parameter logic [7:0] RST_VAL = cmc_pkg::RESULT_RST
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic clear,
  input wire logic [cmc_pkg::DW-1:0] din,
  output logic [cmc_pkg::DW-1:0] dout
);
  import cmc_pkg::*;

  typedef struct packed {
    logic [DW-1:0] val;
  } cmc_byte_s;

  cmc_byte_s s_q;
  cmc_byte_s s_d;

  // a fresh sample beats a clear; both never meet in practice
  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.val = din;
    end
    else if (clear)
    begin
      s_d.val = RST_VAL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q.val <= RST_VAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.val;
endmodule : cmc_result_byte
`default_nettype wire

// ### cmc_top.sv
// Added by the designer: the plain strobed port and the address map.

`timescale 1ns/100ps
`default_nettype none
module cmc_top #(
  parameter int unsigned MEAS_CYCLES = cmc_pkg::TOTAL_MEASURE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [cmc_pkg::AW-1:0] ADDR,
  input wire logic [cmc_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [cmc_pkg::DW-1:0] RDATA,
  output logic INT,
  output logic SENSE_EN,
  output logic EEPROM_EN,
  output logic [1:0] ADC_SEL,
  input wire logic [cmc_pkg::DW-1:0] ADC_DATA,
  output logic [cmc_pkg::COND_NUM*cmc_pkg::DW-1:0] COND_DATA
);
  import cmc_pkg::*;

  // all state of this block but the result bytes and the sequencer in one register; the condition bytes ride in it so reset restores them in one place
  // intr is both the pin and the status flag, so the two can never disagree
  typedef struct packed {
    cmc_mode_e mode;
    logic intr;
    logic clr_pend;
    logic start;
    logic clr_mag;
    logic sense_en;
    logic eep_en;
    logic [DW-1:0] rdata;
    logic [AW-1:0] ptr;
    logic [COND_NUM-1:0][DW-1:0] cond;
  } cmc_top_s;

  // reset image: power-down, nothing pending, pointer parked on the status byte
  localparam cmc_top_s TOP_RST = '{
    mode: MD_PDOWN,
    intr: 1'b0,
    clr_pend: 1'b0,
    start: 1'b0,
    clr_mag: 1'b0,
    sense_en: 1'b0,
    eep_en: 1'b0,
    rdata: ZERO_BYTE,
    ptr: ADDR_STATUS,
    cond: {COND_NUM{COND_RST}}
  };

  cmc_top_s s_q;
  cmc_top_s s_d;
  cmc_meas_if mif ();
  // result bytes, indexed by converter channel
  logic [DW-1:0] res [NUM_CH];

  // measurement sequencer: counts the phases, steers the converter
  // the total measure length is a parameter (each phase is a quarter of it) so a bench can shorten the run
  cmc_meas_seq #(
    .MEAS_CYCLES(MEAS_CYCLES)
  ) u_seq (
    .clk(CLK),
    .rst_n(RST_N),
    .mif(mif.seq)
  );

  // one result byte per channel; temperature is never cleared by mode entry
  // the converter output is same-clock logic, so it is loaded without synchronising
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_res
    cmc_result_byte #(
      .RST_VAL(RESULT_RST)
    ) u_res (
      .clk(CLK),
      .rst_n(RST_N),
      .load(mif.latch && (mif.latch_chan == 2'(g))),
      .clear(s_q.clr_mag && (2'(g) != CH_TEMP)),
      .din(ADC_DATA),
      .dout(res[g])
    );
  end

  // next address of the internal pointer, rolling over inside each bank
  // the current-read alias is the next address after 8'hFE, so an access to 8'hFE leaves the pointer on it
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
    logic [AW-1:0] n;
    n = AW'(a + ADDR_STEP);
    if (a == ADDR_FZ)
    begin
      n = ADDR_STATUS;
    end
    else if (a == ADDR_COND_LAST)
    begin
      n = ADDR_MODE_CTRL;
    end
    return n;
  endfunction : next_addr

  // true for the temperature and field result addresses
  function automatic logic is_result(input logic [AW-1:0] a);
    return (a >= ADDR_TEMP) && (a <= ADDR_FZ);
  endfunction : is_result

  // true for the measurement condition addresses
  function automatic logic is_cond(input logic [AW-1:0] a);
    return (a >= ADDR_COND_FIRST) && (a <= ADDR_COND_LAST);
  endfunction : is_cond

  // decoded bus fields, all combinational
  logic [AW-1:0] rd_addr;
  logic [AW-1:0] res_off;
  logic [AW-1:0] rd_cond_off;
  logic [AW-1:0] wr_cond_off;
  logic [1:0] wr_code;
  logic [DW-1:0] status;
  logic [DW-1:0] rd_val;

  // address decode; the reserved current-read address follows the pointer
  always_comb
  begin
    rd_addr = ADDR;
    if (ADDR == ADDR_CUR_READ)
    begin
      rd_addr = s_q.ptr;
    end
    // offsets wrap below the bank base; only range-checked ones are ever used
    res_off = AW'(rd_addr - ADDR_TEMP);
    rd_cond_off = AW'(rd_addr - ADDR_COND_FIRST);
    wr_cond_off = AW'(ADDR - ADDR_COND_FIRST);
    wr_code = WDATA[MODE_MSB:MODE_LSB];
  end

  // status byte and read mux; write-only and unmapped addresses read zero
  always_comb
  begin
    status = ZERO_BYTE;
    status[ST_INT_BIT] = s_q.intr;
    status[ST_MODE_MSB:ST_MODE_LSB] = mode_code(s_q.mode);
    status[ST_BUSY_BIT] = mif.busy;

    // mode control is write-only, so it falls through to zero like any hole
    rd_val = ZERO_BYTE;
    if (rd_addr == ADDR_STATUS)
    begin
      rd_val = status;
    end
    else if (is_result(rd_addr))
    begin
      rd_val = res[res_off[1:0]];
    end
    else if (is_cond(rd_addr))
    begin
      rd_val = s_q.cond[rd_cond_off[2:0]];
    end
  end

  // bus access, mode control and completion flag
  always_comb
  begin
    s_d = s_q;
    // strobes last one cycle unless raised again below
    s_d.start = 1'b0;
    s_d.clr_mag = 1'b0;
    s_d.clr_pend = 1'b0;
    s_d.rdata = ZERO_BYTE;

    // read: data stands in the following cycle only
    if (RD)
    begin
      s_d.rdata = rd_val;
      // the pointer moves past the byte just read, wherever it came from
      s_d.ptr = next_addr(rd_addr);
      // the clear is held one cycle so the pin drops after the byte has gone
      if (is_result(rd_addr))
      begin
        s_d.clr_pend = 1'b1;
      end
    end

    // a write leaves the pointer on the next byte too; the alias is no real address
    if (WR && (ADDR != ADDR_CUR_READ))
    begin
      s_d.ptr = next_addr(ADDR);
    end

    // condition registers are writable in any mode; only reset restores them
    // the host is expected to change them only in power-down; nothing here enforces it
    if (WR && is_cond(ADDR))
    begin
      s_d.cond[wr_cond_off[2:0]] = WDATA;
    end

    // mode select; measurement and eeprom only from power-down
    // every mode write is accepted on the bus, even when the change is refused
    if (WR && (ADDR == ADDR_MODE_CTRL))
    begin
      case (s_q.mode)
        MD_PDOWN:
        begin
          // the power-down code and unused codes leave the mode as it is
          // a stale completion blocks a new run until it is read away
          if ((wr_code == MODE_MEASURE) && !s_q.intr)
          begin
            s_d.mode = MD_MEASURE;
            s_d.start = 1'b1;
            s_d.clr_mag = 1'b1;
          end
          else if (wr_code == MODE_EEPROM)
          begin
            s_d.mode = MD_EEPROM;
            s_d.clr_mag = 1'b1;
          end
        end
        MD_EEPROM:
        begin
          // leaving eeprom mode goes through power-down only
          // a measurement asked for straight from here is refused
          if (wr_code == MODE_PDOWN)
          begin
            s_d.mode = MD_PDOWN;
          end
        end
        MD_MEASURE:
        begin
          // a running measurement ends by itself; writes change nothing
          s_d.mode = s_q.mode;
        end
        default:
        begin
          s_d.mode = MD_PDOWN;
        end
      endcase
    end

    // automatic return to power-down when the z sample is in
    // the sequencer has already stopped, so the circuitry can go off at once
    if (mif.done)
    begin
      s_d.mode = MD_PDOWN;
    end

    // completion set wins over a clear arriving in the same cycle
    // a lost completion would hang the host, a repeated one only costs a read
    if (mif.done)
    begin
      s_d.intr = 1'b1;
    end
    else if (s_q.clr_pend)
    begin
      s_d.intr = 1'b0;
    end

    // analog blocks powered only in their own mode
    // taken from the next mode so the enables change at the same edge as the mode
    s_d.sense_en = (s_d.mode == MD_MEASURE);
    s_d.eep_en = (s_d.mode == MD_EEPROM);
  end

  // synchronous reset into power-down with default conditions
  // one register for everything but the result bytes and the sequencer keeps the reset image and the next value in step
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_q <= TOP_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // start pulse to the sequencer, one cycle after the accepted request
  assign mif.start = s_q.start;

  // every output straight from a flop
  // the channel select is the sequencer's own channel register
  assign RDATA = s_q.rdata;
  assign INT = s_q.intr;
  assign SENSE_EN = s_q.sense_en;
  assign EEPROM_EN = s_q.eep_en;
  assign ADC_SEL = mif.chan;
  assign COND_DATA = s_q.cond;
endmodule : cmc_top
`default_nettype wire

// ### cmc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_top_monitor #(
  parameter int unsigned MEAS_CYCLES = 40
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [cmc_pkg::AW-1:0] ADDR,
  input wire logic [cmc_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [cmc_pkg::DW-1:0] RDATA,
  input wire logic INT,
  input wire logic SENSE_EN,
  input wire logic EEPROM_EN
);
  import cmc_pkg::*;
  localparam int LO = MEAS_CYCLES - 2;
  localparam int HI = MEAS_CYCLES + 4;
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic rd_res;
  // cycles the measurement power has been on
  always_comb run_d = SENSE_EN ? run_q + 16'h0001 : 16'h0000;
  always_ff @(posedge CLK) run_q <= run_d;
  assign rd_res = RD && (ADDR >= ADDR_TEMP) && (ADDR <= ADDR_FZ);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_meas_req;
    WR && ADDR == ADDR_MODE_CTRL && WDATA[1:0] == MODE_MEASURE && !SENSE_EN && !EEPROM_EN;
  endsequence
  // measurement off, so no completion can race the clear
  sequence s_read_result;
    rd_res && !SENSE_EN;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !INT && !SENSE_EN && !EEPROM_EN)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data without read");
  a_mode_excl: assert property (!(SENSE_EN && EEPROM_EN))
    else $error("two modes at once");
  a_meas_start: assert property (s_meas_req ##0 !INT |=> SENSE_EN)
    else $error("measure request not taken");
  a_busy_ignore: assert property (s_meas_req ##0 INT |=> !SENSE_EN)
    else $error("measure taken while pin high");
  a_done_flag: assert property ($rose(INT) |-> $fell(SENSE_EN))
    else $error("pin rose outside completion");
  a_read_clear: assert property (s_read_result |-> ##2 !INT)
    else $error("pin not cleared by result read");
  a_meas_length: assert property ($fell(SENSE_EN) |-> run_q >= LO && run_q <= HI)
    else $error("measurement length off");
endmodule : cmc_top_monitor
bind cmc_top cmc_top_monitor #(.MEAS_CYCLES(MEAS_CYCLES)) u_mon (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INT(INT), .SENSE_EN(SENSE_EN), .EEPROM_EN(EEPROM_EN));
`default_nettype wire

// ### compass_mode_and_measure_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module compass_mode_and_measure_ctrl_tb;
  import cmc_pkg::*;
  localparam int unsigned MC = 40;
  localparam logic [47:0] COND_EXP = 48'h665544332211;
  logic CLK, RST_N, WR, RD, INT, SENSE_EN, EEPROM_EN;
  logic [7:0] ADDR, WDATA, RDATA, ADC_DATA, d;
  logic [1:0] ADC_SEL;
  logic [47:0] COND_DATA;
  int n_errors, n_tests, n;
  cmc_top #(.MEAS_CYCLES(MC)) DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .INT(INT), .SENSE_EN(SENSE_EN), .EEPROM_EN(EEPROM_EN), .ADC_SEL(ADC_SEL),
    .ADC_DATA(ADC_DATA), .COND_DATA(COND_DATA));
  cmc_adc_model u_adc (.clk(CLK), .en(SENSE_EN), .sel(ADC_SEL), .data(ADC_DATA));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : rd
  task automatic wait_int();
    n = 0;
    while (INT !== 1'b1 && n < 4 * MC)
    begin
      @(posedge CLK);
      #1 n++;
    end
  endtask : wait_int
  task automatic t_reset();
    `CHK({INT, SENSE_EN, EEPROM_EN}, 3'b000)
    `CHK(ADC_SEL, CH_TEMP)
    rd(ADDR_STATUS, d);
    `CHK(d, {5'h00, MODE_PDOWN, 1'b0})
    rd(8'h10, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_COND_FIRST + i[7:0], COND_EXP[8*i+:8]);
    end
    rd(ADDR_COND_LAST, d);
    `CHK(d, 8'h66)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_measure();
    wr(ADDR_MODE_CTRL, {6'h00, MODE_MEASURE});
    `CHK(SENSE_EN, 1'b1)
    wait_int();
    `CHK(n >= MC && n <= MC + 6, 1'b1)
    `CHK(SENSE_EN, 1'b0)
    rd(ADDR_STATUS, d);
    `CHK(d, {5'h00, MODE_PDOWN, 1'b1})
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_TEMP + i[7:0], d);
      `CHK(d, 8'hA0 + i[7:0])
    end
    `CHK(INT, 1'b0)
    rd(ADDR_STATUS, d);
    `CHK(d[0], 1'b0)
    $display("t_measure done");
  endtask : t_measure
  task automatic t_busy();
    `CHK(INT, 1'b0)
    wr(ADDR_MODE_CTRL, {6'h00, MODE_MEASURE});
    wr(ADDR_MODE_CTRL, {6'h00, MODE_EEPROM});
    `CHK(EEPROM_EN, 1'b0)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h08)
    wait_int();
    wr(ADDR_MODE_CTRL, {6'h00, MODE_MEASURE});
    `CHK(SENSE_EN, 1'b0)
    rd(ADDR_STATUS, d);
    rd(ADDR_CUR_READ, d);
    `CHK(d, 8'hA0)
    `CHK(INT, 1'b1)
    @(posedge CLK);
    #1 `CHK(INT, 1'b0)
    $display("t_busy done");
  endtask : t_busy
  task automatic t_eeprom();
    wr(ADDR_MODE_CTRL, 8'h01);
    `CHK({SENSE_EN, EEPROM_EN}, 2'b00)
    wr(ADDR_MODE_CTRL, {6'h00, MODE_EEPROM});
    `CHK(EEPROM_EN, 1'b1)
    rd(ADDR_FZ, d);
    `CHK(d, 8'h00)
    wr(ADDR_MODE_CTRL, {6'h00, MODE_MEASURE});
    `CHK(SENSE_EN, 1'b0)
    wr(ADDR_MODE_CTRL, {6'h00, MODE_PDOWN});
    `CHK(EEPROM_EN, 1'b0)
    `CHK(COND_DATA, COND_EXP)
    // no other mode is asked for after this power-down, so no wait is owed
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    #1 `CHK(COND_DATA, 48'h0)
    rd(ADDR_STATUS, d);
    `CHK(d, {5'h00, MODE_PDOWN, 1'b0})
    $display("t_eeprom done");
  endtask : t_eeprom
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // tests need about 1500 ns
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    {RST_N, WR, RD, ADDR, WDATA} = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_measure();
    t_busy();
    t_eeprom();
    report_and_stop();
  end
endmodule : compass_mode_and_measure_ctrl_tb
`default_nettype wire
